// ==== abi_regs.svh ====
`ifndef ABI_REGS_SVH
`define ABI_REGS_SVH
// register byte offsets on the avalon slave
`define ABI_OFF_BRK_ADDR   8'h00
`define ABI_OFF_BRK_CTRL   8'h04
`define ABI_OFF_IRQ_STAT   8'h08
`define ABI_OFF_IRQ_MASK   8'h0C
`define ABI_OFF_CPU_CC     8'h10
// break control field positions
`define ABI_BIT_BIE        0
`define ABI_BIT_CMF        1
`define ABI_BIT_ADVMODE    2
// irq status/mask bit positions
`define ABI_IRQ_BRK        0
`define ABI_IRQ_NMI        1
`define ABI_IRQ_EXT        2
`define ABI_IRQ_INT        3
// condition code field positions
`define ABI_CC_GMASK       7
`define ABI_CC_UMASK       6
// timing counts in states
`define ABI_PRIO_EXT_ST    3
`define ABI_PRIO_INT_ST    2
`define ABI_MASK_DELAY_ST  2
`define ABI_INTERNAL_ST    1
// reset values
`define ABI_RST_CC         8'h80
`define ABI_RST_ADVMODE    1'b1
`endif

// ==== abi_pkg.sv ====
package abi_pkg;
    // acceptance sequencer states
    typedef enum logic [2:0] {
        ABI_IDLE,
        ABI_PRIO,
        ABI_WAIT_END,
        ABI_INT_ACC,
        ABI_STACK,
        ABI_VECT,
        ABI_INT_VEC
    } abi_state_t;
    // request source encoding, highest priority first
    typedef enum logic [1:0] {
        ABI_SRC_NMI,
        ABI_SRC_BRK,
        ABI_SRC_EXT,
        ABI_SRC_INT
    } abi_src_t;
endpackage

// ==== abi_delay.sv ====
`timescale 1ns/10ps
// ******************************************************************
// delay line used to make mask changes take effect late
// ******************************************************************
module abi_delay #(
    parameter int W     = 2,
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rstn,
    // data
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] stage_r [DEPTH];

    // shift register, reset to all ones (fully masked)
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            for (int i = 0; i < DEPTH; i++) stage_r[i] <= '1;
        end else begin
            stage_r[0] <= din;
            for (int i = 1; i < DEPTH; i++) stage_r[i] <= stage_r[i-1];
        end
    end

    assign dout = stage_r[DEPTH-1];
endmodule // abi_delay

// ==== abi_core.sv ====
// Design decisions made here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/10ps
`include "abi_regs.svh"

// Summary of operation
// - compare prefetch address A23..A1 with break
// - break request only while enable is one
// - match sets flag and requests interrupt
// - break request ignores global and user masks
// - exception starts after current instruction completes
// - normal mode skips bits A23..A16
// - priority takes three external, two internal
// - two internal states: after accept, vector
// - late clear acts after instruction ends
// - higher priority wins over late-disabled one
// - condition code instruction blocks all interrupts
// - new mask acts two states later
// - byte block move blocks all interrupts
// - word block move breaks between transfers
// - acceptance sets global mask bit
module abi_core (
    // clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rstn,
    // avalon-mm slave
    input  wire logic [7:0]           avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    output logic      [31:0]          avs_readdata,
    output logic                      avs_waitrequest,
    // cpu prefetch and instruction status
    input  wire logic                 pf_valid,
    input  wire logic [23:0]          pf_addr,
    input  wire logic                 instr_end,
    input  wire logic                 cc_instr_end,
    input  wire logic [7:0]           cc_instr_value,
    input  wire logic                 move_byte_busy,
    input  wire logic                 move_word_gap,
    input  wire logic [23:0]          next_instr_addr,
    // other interrupt sources
    input  wire logic                 nmi_req,
    input  wire logic                 ext_req,
    input  wire logic                 int_req,
    // exception sequencer handshake
    output logic                      exc_start,
    output abi_pkg::abi_src_t         exc_src,
    output logic      [23:0]          exc_ret_addr,
    output logic                      exc_ret_next,
    output logic                      vect_fetch,
    output logic                      brk_req,
    output logic      [7:0]           cpu_condition_code,
    output logic                      irq
);
    import abi_pkg::*;

    // ************************************************************
    // registers
    // ************************************************************
    logic [23:1] break_address_r;
    logic        break_irq_enable_r;
    logic        break_match_flag_r;
    logic        adv_mode_r;
    logic [3:0]  irq_stat_r;
    logic [3:0]  irq_mask_r;
    logic [7:0]  cc_r;
    logic        ack_r;
    logic        wr_ok;
    logic        rd_ok;
    logic        match;
    logic        global_mask_bit;
    logic        user_mask_bit;
    logic [1:0]  mask_eff;
    logic        block_r;
    logic        ext_pend;
    logic        int_pend;
    logic        req_any;
    logic        gap_ok;
    abi_state_t  state_r;
    abi_state_t  state_nxt;
    abi_src_t    src_r;
    abi_src_t    src_nxt;
    logic [1:0]  cnt_r;
    logic [3:0]  ev;
    logic        prio_last;
    logic        accept_ok;

    assign global_mask_bit = cc_r[`ABI_CC_GMASK];
    assign user_mask_bit   = cc_r[`ABI_CC_UMASK];
    assign cpu_condition_code = cc_r;

    // ************************************************************
    // avalon slave: one wait cycle per access
    // ************************************************************
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
    assign wr_ok = avs_write & ack_r;
    assign rd_ok = avs_read & ~ack_r;

    // acknowledge toggles so every access takes two cycles
    always_ff @(posedge clk_sys) begin
        if (!rstn) ack_r <= 1'b0;
        else       ack_r <= (avs_read | avs_write) & ~ack_r;
    end

    // read data mux, unmapped reads as zero
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            avs_readdata <= 32'h0000_0000;
        end else if (rd_ok) begin
            if (avs_address == `ABI_OFF_BRK_ADDR) begin
                avs_readdata <= {8'h00, break_address_r, 1'b0};
            end else if (avs_address == `ABI_OFF_BRK_CTRL) begin
                avs_readdata <= {29'h0, adv_mode_r, break_match_flag_r,
                                 break_irq_enable_r};
            end else if (avs_address == `ABI_OFF_IRQ_STAT) begin
                avs_readdata <= {28'h0, irq_stat_r};
            end else if (avs_address == `ABI_OFF_IRQ_MASK) begin
                avs_readdata <= {28'h0, irq_mask_r};
            end else if (avs_address == `ABI_OFF_CPU_CC) begin
                avs_readdata <= {24'h0, cc_r};
            end else begin
                avs_readdata <= 32'h0000_0000;
            end
        end
    end

    // ************************************************************
    // break address and control registers
    // ************************************************************
    // break address and control writes
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            break_address_r    <= 23'h0;
            break_irq_enable_r <= 1'b0;
            adv_mode_r         <= `ABI_RST_ADVMODE;
        end else if (wr_ok) begin
            if (avs_address == `ABI_OFF_BRK_ADDR) begin
                break_address_r <= avs_writedata[23:1];
            end else if (avs_address == `ABI_OFF_BRK_CTRL) begin
                break_irq_enable_r <= avs_writedata[`ABI_BIT_BIE];
                adv_mode_r         <= avs_writedata[`ABI_BIT_ADVMODE];
            end
        end
    end

    // ************************************************************
    // address comparator
    // ************************************************************
    always_comb begin
        match = 1'b0;
        if (pf_valid && break_irq_enable_r) begin
            if (adv_mode_r) match = (pf_addr[23:1] == break_address_r);
            else match = (pf_addr[15:1] == break_address_r[15:1]);
        end
    end

    // ************************************************************
    // break match flag and request
    // ************************************************************
    // match flag: set wins over software clear by writing zero
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            break_match_flag_r <= 1'b0;
        end else if (match) begin
            break_match_flag_r <= 1'b1;
        end else if (wr_ok && avs_address == `ABI_OFF_BRK_CTRL
                     && !avs_writedata[`ABI_BIT_CMF]) begin
            break_match_flag_r <= 1'b0;
        end
    end

    assign brk_req = break_match_flag_r & break_irq_enable_r;

    // ************************************************************
    // sticky status, write one to clear, and a plain written mask
    // ************************************************************
    // per-source events: a break match and each accepted nmi, external or internal source
    always_comb begin
        ev = 4'h0;
        ev[`ABI_IRQ_BRK] = match;
        if (state_r == ABI_INT_ACC) begin
            if (src_r == ABI_SRC_NMI) ev[`ABI_IRQ_NMI] = 1'b1;
            if (src_r == ABI_SRC_EXT) ev[`ABI_IRQ_EXT] = 1'b1;
            if (src_r == ABI_SRC_INT) ev[`ABI_IRQ_INT] = 1'b1;
        end
    end

    // status bits: a new event wins over a write-one clear
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            irq_stat_r <= 4'h0;
        end else if (wr_ok && avs_address == `ABI_OFF_IRQ_STAT) begin
            irq_stat_r <= (irq_stat_r & ~avs_writedata[3:0]) | ev;
        end else begin
            irq_stat_r <= irq_stat_r | ev;
        end
    end

    // mask register, same layout as the status
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            irq_mask_r <= 4'h0;
        end else if (wr_ok && avs_address == `ABI_OFF_IRQ_MASK) begin
            irq_mask_r <= avs_writedata[3:0];
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    // ************************************************************
    // condition code: cpu loads, acceptance sets global mask
    // ************************************************************
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            cc_r <= `ABI_RST_CC;
        end else if (state_r == ABI_STACK) begin
            cc_r[`ABI_CC_GMASK] <= 1'b1;
        end else if (cc_instr_end) begin
            cc_r <= cc_instr_value;
        end else if (wr_ok && avs_address == `ABI_OFF_CPU_CC) begin
            cc_r <= avs_writedata[7:0];
        end
    end

    // ************************************************************
    // mask delay and post-instruction guard
    // ************************************************************
    // masks seen by acceptance lag by two states
    abi_delay #(
        .W     (2),
        .DEPTH (`ABI_MASK_DELAY_ST)
    ) u_mask_dly (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .din     ({global_mask_bit, user_mask_bit}),
        .dout    (mask_eff)
    );

    // one instruction guard after a condition code instruction
    always_ff @(posedge clk_sys) begin
        if (!rstn)             block_r <= 1'b0;
        else if (cc_instr_end) block_r <= 1'b1;
        else if (instr_end)    block_r <= 1'b0;
    end

    // ************************************************************
    // acceptance sequencer
    // ************************************************************
    assign ext_pend = ext_req & ~mask_eff[1];
    assign int_pend = int_req & ~(mask_eff[1] & mask_eff[0]);
    assign req_any  = nmi_req | brk_req | ext_pend | int_pend;
    assign gap_ok   = move_word_gap & ~move_byte_busy;
    // a condition code instruction end is never an acceptance point
    assign accept_ok = ((instr_end && !move_byte_busy) || gap_ok)
                       && !block_r && !cc_instr_end;
    // two priority states for internal sources, three otherwise
    assign prio_last = (src_r == ABI_SRC_INT || src_r == ABI_SRC_BRK)
                       ? (cnt_r == 2'(`ABI_PRIO_INT_ST - 1))
                       : (cnt_r == 2'(`ABI_PRIO_EXT_ST - 1));

    // priority select, highest pending wins
    always_comb begin
        src_nxt = src_r;
        if (nmi_req)       src_nxt = ABI_SRC_NMI;
        else if (brk_req)  src_nxt = ABI_SRC_BRK;
        else if (ext_pend) src_nxt = ABI_SRC_EXT;
        else if (int_pend) src_nxt = ABI_SRC_INT;
    end

    // next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ABI_IDLE: begin
                if (req_any) state_nxt = ABI_PRIO;
            end
            ABI_PRIO: begin
                if (!req_any)       state_nxt = ABI_IDLE;
                else if (prio_last) state_nxt = ABI_WAIT_END;
            end
            ABI_WAIT_END: begin
                // a request withdrawn now is still taken at the end
                if (accept_ok) state_nxt = ABI_INT_ACC;
            end
            ABI_INT_ACC:  state_nxt = ABI_STACK;
            ABI_STACK:    state_nxt = ABI_VECT;
            ABI_VECT:     state_nxt = ABI_INT_VEC;
            ABI_INT_VEC:  state_nxt = ABI_IDLE;
            default:      state_nxt = ABI_IDLE;
        endcase
    end

    // sequencer state
    always_ff @(posedge clk_sys) begin
        if (!rstn) state_r <= ABI_IDLE;
        else       state_r <= state_nxt;
    end

    // priority state counter, counts in the priority states, cleared one cycle after leaving them
    always_ff @(posedge clk_sys) begin
        if (!rstn)                    cnt_r <= 2'h0;
        else if (state_r == ABI_PRIO) cnt_r <= cnt_r + 2'h1;
        else                          cnt_r <= 2'h0;
    end

    // source follows the priority select until acceptance, then holds
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            src_r <= ABI_SRC_NMI;
        end else if (state_r == ABI_IDLE || state_r == ABI_PRIO
                     || state_r == ABI_WAIT_END) begin
            src_r <= src_nxt;
        end
    end

    // ************************************************************
    // exception handshake outputs
    // ************************************************************
    // acceptance and vector fetch strobes
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            exc_start  <= 1'b0;
            vect_fetch <= 1'b0;
        end else begin
            exc_start  <= (state_nxt == ABI_INT_ACC);
            vect_fetch <= (state_nxt == ABI_VECT);
        end
    end

    // source and return address captured at acceptance
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            exc_src      <= ABI_SRC_NMI;
            exc_ret_addr <= 24'h0;
            exc_ret_next <= 1'b0;
        end else begin
            if (state_r == ABI_WAIT_END && state_nxt == ABI_INT_ACC) begin
                exc_src      <= src_nxt;
                exc_ret_addr <= next_instr_addr;
                exc_ret_next <= gap_ok;
            end
        end
    end
endmodule // abi_core

// ==== abi_core_sva.sv ====
`timescale 1ns/10ps
// ************************************************************
// checker for the break match and acceptance sequencer
// ************************************************************
module abi_core_sva (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        rstn,
    // bus and cpu side
    input wire logic        avs_write,
    input wire logic        pf_valid,
    input wire logic        instr_end,
    input wire logic        cc_instr_end,
    input wire logic        move_byte_busy,
    input wire logic        move_word_gap,
    input wire logic [23:0] next_instr_addr,
    input wire logic        ext_req,
    // sequencer outputs
    input wire logic        exc_start,
    input wire logic [23:0] exc_ret_addr,
    input wire logic        exc_ret_next,
    input wire logic        vect_fetch,
    input wire logic        brk_req,
    input wire logic [7:0]  cpu_condition_code
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // stack cycle then vector fetch
    sequence s_vect;
        ##[1:3] vect_fetch;
    endsequence
    // global mask rises once the stack is written
    sequence s_gmask;
        ##[1:4] cpu_condition_code[7];
    endsequence
    AST_BRK_CAUSE: assert property (
        $rose(brk_req) |-> $past(pf_valid) || $past(avs_write))
        else $error("break request rose without prefetch or write");
    AST_BRK_HOLD: assert property (
        brk_req && !avs_write |=> brk_req)
        else $error("break request dropped without software write");
    AST_VECT_AFTER: assert property (
        exc_start |-> s_vect)
        else $error("no vector fetch after acceptance");
    AST_GMASK_SET: assert property (
        exc_start |-> s_gmask)
        else $error("global mask not set after acceptance");
    AST_AT_END: assert property (
        exc_start |-> $past(instr_end) || $past(move_word_gap))
        else $error("acceptance outside an instruction end");
    AST_BYTE_MOVE: assert property (
        exc_start |-> !$past(move_byte_busy))
        else $error("acceptance during byte block move");
    AST_CC_GUARD: assert property (
        exc_start |-> !$past(cc_instr_end))
        else $error("acceptance right after condition code instruction");
    AST_RET_NEXT: assert property (
        exc_start && exc_ret_next |-> $past(move_word_gap) && exc_ret_addr == $past(next_instr_addr))
        else $error("wrong return address at word move gap");
    AST_EXT_PRIO: assert property (
        $rose(ext_req) |-> !exc_start [*3])
        else $error("external request accepted before priority states");
endmodule // abi_core_sva

bind abi_core abi_core_sva u_sva (
    .clk_sys, .rstn, .avs_write, .pf_valid, .instr_end, .cc_instr_end, .move_byte_busy,
    .move_word_gap, .next_instr_addr, .ext_req, .exc_start, .exc_ret_addr, .exc_ret_next,
    .vect_fetch, .brk_req, .cpu_condition_code
);

// ==== abi_cpu_model.sv ====
`timescale 1ns/10ps
// ************************************************************
// cpu core model: prefetch strobes, instruction ends, moves
// ************************************************************
module abi_cpu_model (
    // clock and reset
    input  wire logic   clk_sys,
    input  wire logic   rstn,
    // prefetch and instruction status
    output logic        pf_valid,
    output logic [23:0] pf_addr,
    output logic        instr_end,
    output logic        cc_instr_end,
    output logic [7:0]  cc_instr_value,
    output logic        move_byte_busy,
    output logic        move_word_gap,
    output logic [23:0] next_instr_addr
);
    logic [1:0] phase_r;
    logic       hold_r;
    // quiet start values
    initial begin
        {pf_valid, instr_end, cc_instr_end, move_byte_busy, move_word_gap, hold_r} = 6'h00;
        pf_addr = 24'hFFFFFF;
        cc_instr_value = 8'h80;
        next_instr_addr = 24'h002468;
        phase_r = 2'h0;
    end
    // an instruction ends every fourth cycle unless a move holds it
    always @(posedge clk_sys) begin
        phase_r <= phase_r + 2'h1;
        instr_end <= rstn && (phase_r == 2'h3) && !move_byte_busy && !hold_r;
    end
    // one prefetch of an instruction start
    task automatic prefetch(input logic [23:0] a);
        @(posedge clk_sys);
        pf_valid <= 1'b1;
        pf_addr <= a;
        @(posedge clk_sys);
        pf_valid <= 1'b0;
        pf_addr <= ~a; // released bus shows no stale address
    endtask
    // byte block move: no instruction end while busy
    task automatic byte_move(input int n);
        @(posedge clk_sys);
        move_byte_busy <= 1'b1;
        repeat (n) @(posedge clk_sys);
        move_byte_busy <= 1'b0;
    endtask
    // word block move: gaps between transfers, no instruction end
    task automatic word_move(input int n);
        @(posedge clk_sys);
        hold_r <= 1'b1;
        repeat (n) begin
            repeat (2) @(posedge clk_sys);
            move_word_gap <= 1'b1;
            @(posedge clk_sys);
            move_word_gap <= 1'b0;
        end
        hold_r <= 1'b0;
    endtask
    // condition code instruction: end strobe with the new code
    task automatic cc_instr(input logic [7:0] v);
        @(posedge clk_sys);
        cc_instr_end <= 1'b1;
        cc_instr_value <= v;
        @(posedge clk_sys);
        cc_instr_end <= 1'b0;
    endtask
endmodule // abi_cpu_model

// ==== abi_core_test.sv ====
`timescale 1ns/10ps
`include "abi_regs.svh"
// ************************************************************
// bench for the address break and acceptance block
// ************************************************************
module abi_core_test;
    import abi_pkg::*;
    logic        clk_sys, rstn, avs_read, avs_write, avs_waitrequest, irq;
    logic [7:0]  avs_address, cc_instr_value, cpu_condition_code;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic        pf_valid, instr_end, cc_instr_end, move_byte_busy, move_word_gap;
    logic [23:0] pf_addr, next_instr_addr, exc_ret_addr, seen_ret;
    logic        nmi_req, ext_req, int_req, exc_start, exc_ret_next, vect_fetch, brk_req;
    logic        seen, seen_next;
    abi_src_t    exc_src, seen_src;
    int          miscompares = 0, n_compared = 0, cycles = 0;

    abi_core uut (.clk_sys, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .pf_valid, .pf_addr, .instr_end, .cc_instr_end,
        .cc_instr_value, .move_byte_busy, .move_word_gap, .next_instr_addr, .nmi_req,
        .ext_req, .int_req, .exc_start, .exc_src, .exc_ret_addr, .exc_ret_next,
        .vect_fetch, .brk_req, .cpu_condition_code, .irq);
    abi_cpu_model cpu (.clk_sys, .rstn, .pf_valid, .pf_addr, .instr_end, .cc_instr_end,
        .cc_instr_value, .move_byte_busy, .move_word_gap, .next_instr_addr);

    // ************************************************************
    // clock, timeout and shared tasks
    // ************************************************************
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic av_wr(input logic [7:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic av_rd(input logic [7:0] a, output logic [31:0] d);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
        @(posedge clk_sys);
    endtask
    // waits a bounded time for one acceptance pulse
    task automatic wait_exc();
        seen = 1'b0;
        repeat (80) begin
            @(posedge clk_sys);
            if (exc_start === 1'b1) begin
                {seen, seen_src, seen_next, seen_ret} = {1'b1, exc_src, exc_ret_next, exc_ret_addr};
                break;
            end
        end
    endtask

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        {rstn, avs_read, avs_write, nmi_req, ext_req, int_req} = 6'h00;
        avs_address = 8'h00;
        avs_writedata = 32'h00000000;
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        // reset values, then clear any stale status
        av_rd(`ABI_OFF_CPU_CC, rd);
        chk("cc reset", rd, 32'h00000080);
        av_rd(`ABI_OFF_BRK_CTRL, rd);
        chk("ctrl reset", rd, 32'h00000004);
        av_rd(`ABI_OFF_IRQ_STAT, rd);
        av_wr(`ABI_OFF_IRQ_STAT, rd);
        $display("test reset done");
        // break taken although global mask is set
        av_wr(`ABI_OFF_BRK_ADDR, 32'h00001234);
        av_wr(`ABI_OFF_BRK_CTRL, 32'h00000005);
        cpu.prefetch(24'h001234);
        @(posedge clk_sys);
        chk("brk_req match", 32'(brk_req), 32'h1);
        wait_exc();
        chk("brk accepted", 32'(seen), 32'h1);
        chk("brk source", 32'(seen_src), 32'(ABI_SRC_BRK));
        av_rd(`ABI_OFF_BRK_CTRL, rd);
        chk("flag kept", rd, 32'h00000007);
        av_wr(`ABI_OFF_BRK_CTRL, 32'h00000004);
        chk("brk_req cleared", 32'(brk_req), 32'h0);
        $display("test break done");
        // disabled break and upper address mismatch
        cpu.prefetch(24'h001234);
        @(posedge clk_sys);
        chk("brk_req disabled", 32'(brk_req), 32'h0);
        av_wr(`ABI_OFF_BRK_CTRL, 32'h00000005);
        cpu.prefetch(24'h011234);
        @(posedge clk_sys);
        chk("brk_req upper bits", 32'(brk_req), 32'h0);
        // normal mode ignores A23..A16
        av_wr(`ABI_OFF_BRK_CTRL, 32'h00000001);
        av_wr(`ABI_OFF_BRK_ADDR, 32'h00AB1234);
        cpu.prefetch(24'h011234);
        @(posedge clk_sys);
        chk("brk_req normal", 32'(brk_req), 32'h1);
        av_wr(`ABI_OFF_BRK_CTRL, 32'h00000004);
        $display("test compare done");
        // nmi held off by byte block move
        fork
            cpu.byte_move(12);
            begin
                @(posedge clk_sys);
                nmi_req <= 1'b1;
            end
        join
        wait_exc();
        nmi_req <= 1'b0;
        chk("nmi after move", 32'(seen_src), 32'(ABI_SRC_NMI));
        $display("test byte move done");
        // external request taken at a word move gap
        av_wr(`ABI_OFF_CPU_CC, 32'h00000000);
        ext_req <= 1'b1;
        fork
            cpu.word_move(4);
            begin
                wait_exc();
                ext_req <= 1'b0;
            end
        join
        chk("ext source", 32'(seen_src), 32'(ABI_SRC_EXT));
        chk("ret next", 32'(seen_next), 32'h1);
        chk("ret addr", 32'(seen_ret), 32'h00002468);
        av_rd(`ABI_OFF_CPU_CC, rd);
        chk("gmask set", 32'(rd[7]), 32'h1);
        $display("test word move done");
        // internal request held by both masks, freed by a cc load
        av_wr(`ABI_OFF_CPU_CC, 32'h000000C0);
        repeat (2) @(posedge clk_sys);
        int_req <= 1'b1;
        wait_exc();
        chk("int masked", 32'(seen), 32'h0);
        cpu.cc_instr(8'h00);
        wait_exc();
        int_req <= 1'b0;
        chk("int seen", 32'(seen), 32'h1);
        chk("int source", 32'(seen_src), 32'(ABI_SRC_INT));
        $display("test internal done");
        // interrupt line: mask both ways, then clear
        av_wr(`ABI_OFF_IRQ_MASK, 32'h00000000);
        chk("irq masked", 32'(irq), 32'h0);
        av_wr(`ABI_OFF_IRQ_MASK, 32'h0000000F);
        chk("irq unmasked", 32'(irq), 32'h1);
        av_wr(`ABI_OFF_IRQ_STAT, 32'h0000000F);
        av_rd(`ABI_OFF_IRQ_STAT, rd);
        chk("status cleared", rd, 32'h00000000);
        chk("irq cleared", 32'(irq), 32'h0);
        av_rd(8'hF0, rd);
        chk("unmapped read", rd, 32'h00000000);
        $display("test interrupt line done");
        give_verdict();
    end
endmodule // abi_core_test
